// file: bench/dps_pad_load.sv
// Pad buffer load model: data pad drive in quarter units of 1X.
// Assumes the code is a static level from the strength bank.
`default_nettype none
module dps_pad_load (
  // Code in
  input wire logic [2:0] code,
  // Drive out
  output logic [4:0] drive
);
  timeunit 1ns;
  timeprecision 1ns;
  // Upper half steps by half units, top code jumps to 4X
  assign drive = code[2] ? (code == 3'h7 ? 5'h10 : 5'h08 + {code[1:0], 1'h0})
    : 5'h03 + code;
endmodule
`default_nettype wire

// file: bench/dps_pad_strength_asserts.sv
// Port checks for the pad strength bank, bound onto its top module.
// Assumes one clock with a synchronous active-high reset.
`default_nettype none
module dps_pad_strength_chk #(
  parameter ADDR_W = 9,
  parameter ROWS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_r,
  input wire logic reg_rvalid_r,
  // Pad codes
  input wire logic [2:0] command_strength_r,
  input wire logic [2:0] data_strobe_strength_r,
  input wire logic [3*ROWS-1:0] memory_clock_enable_strength_r,
  input wire logic [3*ROWS-1:0] memory_chip_select_n_strength_r,
  input wire logic [3*(ROWS/2)-1:0] memory_clock_true_strength_r,
  input wire logic [3*(ROWS/2)-1:0] memory_clock_complement_strength_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic at_str = reg_addr[ADDR_W-1:2] == 7'h0C;
  wire logic str_wr = reg_wr && at_str;
  wire logic [6*ROWS+3*(ROWS/2)+5:0] codes = {command_strength_r,
    data_strobe_strength_r, memory_clock_enable_strength_r,
    memory_chip_select_n_strength_r, memory_clock_true_strength_r};
  AST_RD_ANS: assert property (reg_rd |=> reg_rvalid_r)
    else $error("read not answered");
  AST_RD_IDLE: assert property (!reg_rd |=> !reg_rvalid_r)
    else $error("stray read valid");
  AST_RSVD: assert property (reg_rvalid_r && $past(at_str) |->
    (reg_rdata_r & 32'h88888888) == 32'h0) else $error("reserved bit set");
  AST_CMD: assert property (str_wr && reg_be[0] |=>
    command_strength_r == $past(reg_wdata[6:4])) else $error("cmd code");
  AST_DATA: assert property (str_wr && reg_be[0] |=>
    data_strobe_strength_r == $past(reg_wdata[2:0])) else $error("data code");
  AST_CKE: assert property (str_wr && reg_be[1] |=>
    memory_clock_enable_strength_r[2:0] == $past(reg_wdata[14:12]) ||
    memory_clock_enable_strength_r[2:0] == $past(reg_wdata[10:8]))
    else $error("cke code");
  AST_CLK_PAIR: assert property (memory_clock_true_strength_r ==
    memory_clock_complement_strength_r) else $error("clock pair differs");
  AST_HOLD: assert property (!reg_wr |=> $stable(codes))
    else $error("code moved");
  cover property (str_wr && reg_be == 4'hF);
  cover property (reg_wr && reg_addr[ADDR_W-1:2] == 7'h0B);
  cover property (reg_rvalid_r);
endmodule
bind dps_pad_strength dps_pad_strength_chk #(.ADDR_W(ADDR_W), .ROWS(ROWS))
  u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
    .command_strength_r(command_strength_r),
    .data_strobe_strength_r(data_strobe_strength_r),
    .memory_clock_enable_strength_r(memory_clock_enable_strength_r),
    .memory_chip_select_n_strength_r(memory_chip_select_n_strength_r),
    .memory_clock_true_strength_r(memory_clock_true_strength_r),
    .memory_clock_complement_strength_r(memory_clock_complement_strength_r));
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the pad strength bank.
// Assumes hw/ on the include path; inputs change on the falling edge.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [8:0] reg_addr = 9'h000;
  logic [3:0] reg_be = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_r;
  logic reg_rvalid_r;
  logic [2:0] command_strength_r, data_strobe_strength_r;
  logic [11:0] memory_clock_enable_strength_r, memory_chip_select_n_strength_r;
  logic [5:0] memory_clock_true_strength_r, memory_clock_complement_strength_r;
  logic [4:0] drive;
  logic [4:0] units [8] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0A, 5'h0C,
    5'h10};
  int bad_count = 0, compares = 0;
  dps_pad_strength uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
    .command_strength_r(command_strength_r),
    .data_strobe_strength_r(data_strobe_strength_r),
    .memory_clock_enable_strength_r(memory_clock_enable_strength_r),
    .memory_chip_select_n_strength_r(memory_chip_select_n_strength_r),
    .memory_clock_true_strength_r(memory_clock_true_strength_r),
    .memory_clock_complement_strength_r(memory_clock_complement_strength_r));
  dps_pad_load load (.code(data_strobe_strength_r), .drive(drive));
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [3:0] b,
    input logic [31:0] d);
    @(negedge clk);
    {reg_addr, reg_be, reg_wdata, reg_wr} = {a, b, d, 1'h1};
    @(negedge clk);
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(negedge clk);
    {reg_addr, reg_rd} = {a, 1'h1};
    @(negedge clk);
    reg_rd = 1'h0;
    chk("rvalid", 32'h1, {31'h0, reg_rvalid_r});
    chk("rdata", e, reg_rdata_r);
  endtask
  // Pads: {cke, cs} then {cmd, data, clock pairs}
  task automatic outs(input logic [23:0] e1, input logic [11:0] e2);
    chk("cke_cs", {8'h0, e1}, {8'h0, memory_clock_enable_strength_r,
      memory_chip_select_n_strength_r});
    chk("cmd_clk", {20'h0, e2}, {20'h0, command_strength_r,
      data_strobe_strength_r, memory_clock_true_strength_r});
    chk("ck_pair", {26'h0, e2[5:0]},
      {26'h0, memory_clock_complement_strength_r});
  endtask
  task automatic results;
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  initial begin
    #100000;
    bad_count++;
    results();
  end
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'h0;
    outs(24'h0, 12'h0);
    rd(9'h030, 32'h0);
    rd(9'h02C, 32'h0);
    wr(9'h030, 4'hF, 32'hFFFFFFFF);
    rd(9'h030, 32'h77777777);
    outs(24'hFFFFFF, 12'hFFF);
    for (int i = 0; i < 8; i++) begin
      wr(9'h030, 4'h1, {25'h0, 3'(i), 1'h0, 3'(7 - i)});
      chk("drive", {27'h0, units[7-i]}, {27'h0, drive});
    end
    wr(9'h030, 4'hE, 32'h43526100);
    rd(9'h030, 32'h43526170);
    outs(24'hDB6B6D, 12'hE24);
    wr(9'h02C, 4'h1, 32'h000000F5);
    rd(9'h02C, 32'h00000005);
    outs(24'hC71AAA, 12'hE1B);
    wr(9'h02C, 4'h1, 32'h00000008);
    outs(24'h3B656D, 12'hE1C);
    wr(9'h040, 4'hF, 32'hFFFFFFFF);
    rd(9'h040, 32'h0);
    rd(9'h030, 32'h43526170);
    sys_rst = 1'h1;
    @(negedge clk);
    sys_rst = 1'h0;
    outs(24'h0, 12'h0);
    rd(9'h030, 32'h0);
    rd(9'h02C, 32'h0);
    results();
  end
endmodule
`default_nettype wire

// file: hw/dps_byte_reg.v
// One 8-bit read/write configuration register with a fixed writable mask.
// Assumes a synchronous, active-high reset and a one-cycle write strobe.
`include "dps_defines.vh"
`default_nettype none

module dps_byte_reg #(
  parameter [7:0] WR_MASK = `DPS_STR_MASK,
  parameter [7:0] RST_VAL = `DPS_STR_RESET
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Write side
  input wire wr_en,
  input wire [7:0] wr_byte,
  // Stored value and the value it takes at the next edge when reset is low
  output reg [7:0] q_r,
  output reg [7:0] q_nxt
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always @* begin
    q_nxt = q_r;
    if (wr_en) begin
      // Masked bits stay zero whatever is written
      q_nxt = wr_byte & WR_MASK;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      q_r <= RST_VAL & WR_MASK;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule
`default_nettype wire

// file: hw/dps_defines.vh
// Offsets, field positions, masks and reset values of the pad strength bank.
// Assumes byte offsets inside the memory-mapped window, dword aligned.
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, dword holding them)
// ----------------------------------------------------------------
`define DPS_OFS_ROW_WIDTH 9'h02C
`define DPS_OFS_STR_DWORD 9'h030
`define DPS_OFS_DATA_CMD 9'h030
`define DPS_OFS_CKE 9'h031
`define DPS_OFS_CS 9'h032
`define DPS_OFS_CLK 9'h033

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define DPS_X16_MSB 6
`define DPS_X16_LSB 4
`define DPS_X8_MSB 2
`define DPS_X8_LSB 0
`define DPS_STR_MASK 8'h77
`define DPS_ROW_WIDTH_MASK 8'h0F
`define DPS_STR_RESET 8'h00
`define DPS_ROW_WIDTH_RESET 8'h00
`define DPS_CODE_RESET 3'h0

`endif

// file: hw/dps_pad_strength.v
// DDR pad drive-strength register bank and per-group code selection.
// Assumes single aligned dword-or-smaller accesses on the register port.
// Assumes the row width byte sits in this bank, lane 0 of dword 02Ch.
//
// Operation
// - Register 30h, read/write, resets to zero
// - 30h bits 6:4 drive command/address outputs
// - 30h bits 2:0 drive data and strobes
// - Three-bit code, eight strengths, resets 000
// - Register 31h, bits 6:4 x16 clock-enable
// - 31h bits 2:0 x8 clock-enable code
// - Register 32h, resets zero, 6:4 x16 select
// - 32h bits 2:0 x8 chip-select code
// - Register 33h, resets zero, 6:4 x16 clock
// - 33h bits 2:0 x8 clock code
// - Clock code drives true and complement alike
// - Row width bits pick x8 or x16
// - x8 and x16 codes stored separately
// - Row width bit: 1 x8, 0 x16/empty
`include "dps_defines.vh"
`default_nettype none

module dps_pad_strength #(
  parameter ADDR_W = 9,
  parameter ROWS = 4
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [3:0] reg_be,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_r,
  output reg reg_rvalid_r,
  // Pad strength codes
  output reg [2:0] command_strength_r,
  output reg [2:0] data_strobe_strength_r,
  output reg [3*ROWS-1:0] memory_clock_enable_strength_r,
  output reg [3*ROWS-1:0] memory_chip_select_n_strength_r,
  output reg [3*(ROWS/2)-1:0] memory_clock_true_strength_r,
  output reg [3*(ROWS/2)-1:0] memory_clock_complement_strength_r
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Low address bits are ignored: accesses are naturally aligned
  wire [ADDR_W-1:0] dword_addr = {reg_addr[ADDR_W-1:2], 2'h0};
  wire str_hit = (dword_addr == `DPS_OFS_STR_DWORD);
  wire width_hit = (dword_addr == `DPS_OFS_ROW_WIDTH);

  // ----------------------------------------------------------------
  // Strength registers, one byte lane each
  // ----------------------------------------------------------------
  wire [31:0] str_q;
  wire [31:0] str_nxt;

  // Four byte lanes of one dword hold the four strength registers
  localparam LANES = 4;
  genvar i;
  generate
    for (i = 0; i < LANES; i = i + 1) begin : g_str
      // Lane 0 at 30h, lane 1 at 31h, lane 2 at 32h, lane 3 at 33h
      dps_byte_reg #(
        .WR_MASK(`DPS_STR_MASK),
        .RST_VAL(`DPS_STR_RESET)
      ) u_str (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(reg_wr & str_hit & reg_be[i]),
        .wr_byte(reg_wdata[8*i+7:8*i]),
        .q_r(str_q[8*i+7:8*i]),
        .q_nxt(str_nxt[8*i+7:8*i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Row device width register
  // ----------------------------------------------------------------
  wire [7:0] width_q;
  wire [7:0] width_nxt;

  dps_byte_reg #(
    .WR_MASK(`DPS_ROW_WIDTH_MASK),
    .RST_VAL(`DPS_ROW_WIDTH_RESET)
  ) u_row_width (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(reg_wr & width_hit & reg_be[0]),
    .wr_byte(reg_wdata[7:0]),
    .q_r(width_q),
    .q_nxt(width_nxt)
  );

  // ----------------------------------------------------------------
  // Field views of the next register values
  // ----------------------------------------------------------------
  // Using next values lets the pads follow on the writing edge itself
  wire [7:0] dc_nxt = str_nxt[7:0];
  wire [7:0] cke_nxt = str_nxt[15:8];
  wire [7:0] cs_nxt = str_nxt[23:16];
  wire [7:0] clk_nxt = str_nxt[31:24];
  wire [ROWS-1:0] row_x8 = width_nxt[ROWS-1:0];

  // Each lane keeps x16 and x8 codes in separate fields
  wire [2:0] cke_x16 = cke_nxt[`DPS_X16_MSB:`DPS_X16_LSB];
  wire [2:0] cke_x8 = cke_nxt[`DPS_X8_MSB:`DPS_X8_LSB];
  wire [2:0] cs_x16 = cs_nxt[`DPS_X16_MSB:`DPS_X16_LSB];
  wire [2:0] cs_x8 = cs_nxt[`DPS_X8_MSB:`DPS_X8_LSB];
  wire [2:0] ck_x16 = clk_nxt[`DPS_X16_MSB:`DPS_X16_LSB];
  wire [2:0] ck_x8 = clk_nxt[`DPS_X8_MSB:`DPS_X8_LSB];

  // ----------------------------------------------------------------
  // Pad code selection
  // ----------------------------------------------------------------
  // One clocked driver per output; the per-row choice is plain wiring
  wire [3*ROWS-1:0] cke_sel;
  wire [3*ROWS-1:0] cs_sel;
  wire [3*(ROWS/2)-1:0] ck_sel;

  genvar r;
  generate
    for (r = 0; r < ROWS; r = r + 1) begin : g_row
      assign cke_sel[3*r+2:3*r] = row_x8[r] ? cke_x8 : cke_x16;
      assign cs_sel[3*r+2:3*r] = row_x8[r] ? cs_x8 : cs_x16;
    end
    // A clock pair feeds two rows; one x8 row is enough to load it as x8
    for (r = 0; r < ROWS/2; r = r + 1) begin : g_ck
      wire pair_x8 = row_x8[2*r] | row_x8[2*r+1];
      assign ck_sel[3*r+2:3*r] = pair_x8 ? ck_x8 : ck_x16;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pad code registers
  // ----------------------------------------------------------------
  reg [2:0] command_strength_nxt;
  reg [2:0] data_strobe_strength_nxt;
  reg [3*ROWS-1:0] memory_clock_enable_strength_nxt;
  reg [3*ROWS-1:0] memory_chip_select_n_strength_nxt;
  reg [3*(ROWS/2)-1:0] memory_clock_true_strength_nxt;
  reg [3*(ROWS/2)-1:0] memory_clock_complement_strength_nxt;

  // Reset is folded in here so the clocked block is a plain copy
  always @* begin
    command_strength_nxt = dc_nxt[`DPS_X16_MSB:`DPS_X16_LSB];
    data_strobe_strength_nxt = dc_nxt[`DPS_X8_MSB:`DPS_X8_LSB];
    memory_clock_enable_strength_nxt = cke_sel;
    memory_chip_select_n_strength_nxt = cs_sel;
    memory_clock_true_strength_nxt = ck_sel;
    // Both halves of the differential pair share one code
    memory_clock_complement_strength_nxt = ck_sel;
    if (sys_rst) begin
      command_strength_nxt = `DPS_CODE_RESET;
      data_strobe_strength_nxt = `DPS_CODE_RESET;
      memory_clock_enable_strength_nxt = {ROWS{`DPS_CODE_RESET}};
      memory_chip_select_n_strength_nxt = {ROWS{`DPS_CODE_RESET}};
      memory_clock_true_strength_nxt = {(ROWS/2){`DPS_CODE_RESET}};
      memory_clock_complement_strength_nxt = {(ROWS/2){`DPS_CODE_RESET}};
    end
  end

  // Static levels to the pads: they move only on a write or a reset
  always @(posedge clk) begin
    command_strength_r <= command_strength_nxt;
    data_strobe_strength_r <= data_strobe_strength_nxt;
    memory_clock_enable_strength_r <= memory_clock_enable_strength_nxt;
    memory_chip_select_n_strength_r <= memory_chip_select_n_strength_nxt;
    memory_clock_true_strength_r <= memory_clock_true_strength_nxt;
    memory_clock_complement_strength_r <=
      memory_clock_complement_strength_nxt;
  end

  // ----------------------------------------------------------------
  // Read word select
  // ----------------------------------------------------------------
  // Unmapped dwords read as zero; reserved bits are zero in storage
  reg [31:0] read_word;

  always @* begin
    read_word = 32'h00000000;
    if (str_hit) begin
      read_word = str_q;
    end else if (width_hit) begin
      read_word = {24'h000000, width_q};
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Stored values are read, so a read in a writing cycle sees the old one
  reg [31:0] reg_rdata_nxt;
  reg reg_rvalid_nxt;

  // Read data hold between reads for a master that samples late
  always @* begin
    reg_rvalid_nxt = reg_rd;
    reg_rdata_nxt = reg_rdata_r;
    if (reg_rd) begin
      reg_rdata_nxt = read_word;
    end
    if (sys_rst) begin
      reg_rvalid_nxt = 1'h0;
      reg_rdata_nxt = 32'h00000000;
    end
  end

  always @(posedge clk) begin
    reg_rdata_r <= reg_rdata_nxt;
    reg_rvalid_r <= reg_rvalid_nxt;
  end

endmodule
`default_nettype wire
